// *** design/cdp_pkg.sv ***
// channel decay and pulse counter: shared constants and types
// assumes a 10 MHz pclk and an apb master with 32-bit data
package cdp_pkg;

  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FILT = 8'h04;
  localparam logic [7:0] A_MEAS = 8'h08;
  localparam logic [7:0] A_REC = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_CNT = 8'h14;

  // field positions
  localparam int F_MODE = 0;
  localparam int F_DEC = 2;
  localparam int F_WIN = 8;
  localparam int F_BUSY = 0;
  localparam int F_ERR = 1;
  localparam int F_LVL = 2;

  // reset values and limits
  localparam logic [6:0] RST_WIN = 7'h01;
  localparam logic [6:0] WIN_MAX = 7'h40;
  localparam logic [5:0] DIV_LAST = 6'h27;
  localparam logic [5:0] SQRT_TOP = 6'h0f;

  // filter time unit and clock period
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 100;
  localparam int MS_CYC = MS_NS / CLK_NS;

  typedef enum logic [1:0] {
    M_INTV = 2'h0,
    M_DAY = 2'h1,
    M_ANA = 2'h2
  } cdp_mode_e;

  typedef enum logic [2:0] {
    D_OFF = 3'h0,
    D_MIN = 3'h1,
    D_MAX = 3'h2,
    D_AVG = 3'h3,
    D_MED = 3'h4,
    D_RMS = 3'h5,
    D_SUM = 3'h6
  } cdp_dec_e;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_AVG = 7'h02,
    ST_PUSH = 7'h04,
    ST_SCAN = 7'h08,
    ST_DIV = 7'h10,
    ST_SQRT = 7'h20,
    ST_MED = 7'h40
  } cdp_st_e;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } cdp_rec_s;

endpackage : cdp_pkg

// *** design/cdp_top.sv ***
// channel decay and pulse counter for one logger channel
// assumes tick inputs are one-cycle pulses on pclk; pulse pin is async
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps

module cdp_top #(
  parameter int MS_CYCLES = cdp_pkg::MS_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor side
  input wire logic pulse_pin,
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  // timing strobes
  input wire logic meas_tick,
  input wire logic rec_tick,
  input wire logic midnight,
  // record store
  output cdp_pkg::cdp_rec_s rec
);

  typedef struct packed {
    logic [2:0] sy;
    logic flt;
    logic [15:0] db;
    logic [31:0] msc;
    logic [15:0] pcnt;
    logic [15:0] sacc;
    logic [31:0] a_sum;
    logic [15:0] a_n;
    logic [15:0] a_ms;
    logic [31:0] av_sum;
    logic [15:0] av_n;
    cdp_pkg::cdp_mode_e mode;
    cdp_pkg::cdp_dec_e dec;
    logic [6:0] win_n;
    logic [15:0] filt;
    logic err;
    logic [15:0] meas;
    logic [15:0] result;
    logic [63:0][15:0] win;
    logic [5:0] wp;
    logic [6:0] nfill;
    cdp_pkg::cdp_st_e st;
    logic [6:0] n;
    logic [6:0] i;
    logic [6:0] j;
    logic [6:0] less;
    logic [6:0] eq;
    logic [15:0] mn;
    logic [15:0] mx;
    logic [39:0] sum;
    logic [39:0] sq;
    logic [39:0] dvd;
    logic [39:0] rem;
    logic [15:0] dvs;
    logic [5:0] bitc;
    logic [15:0] root;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cdp_pkg::cdp_rec_s rec;
  } cdp_state_s;

  cdp_state_s s;
  cdp_state_s nx;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // slot of the k-th newest window entry
  function automatic logic [5:0] widx(input logic [5:0] wp,
                                      input logic [6:0] k);
    widx = wp - 6'h01 - k[5:0];
  endfunction : widx

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == cdp_pkg::A_CTRL) || (a == cdp_pkg::A_FILT) ||
              (a == cdp_pkg::A_MEAS) || (a == cdp_pkg::A_REC) ||
              (a == cdp_pkg::A_STAT) || (a == cdp_pkg::A_CNT);
  endfunction : reg_hit

  // one restoring division step: {remainder, dividend/quotient}
  function automatic logic [79:0] div_step(input logic [39:0] r,
                                           input logic [39:0] d,
                                           input logic [15:0] v);
    logic [40:0] t;
    t = {r, d[39]};
    if (t >= {25'h0, v}) begin
      div_step = {40'(t - {25'h0, v}), d[38:0], 1'b1};
    end else begin
      div_step = {t[39:0], d[38:0], 1'b0};
    end
  endfunction : div_step

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic tick;
    logic p;
    logic take;
    logic [6:0] nn;
    logic [6:0] fld;
    logic [15:0] v;
    logic [15:0] w;
    logic [15:0] t;
    logic [39:0] sm;
    logic [39:0] sqv;
    logic [6:0] lt;
    logic [6:0] eqv;
    logic [6:0] kk;
    logic [31:0] asum;
    logic [15:0] an;
    cdp_pkg::cdp_dec_e nd;
    nx = s;
    tick = (s.msc == 32'(MS_CYCLES - 1));
    p = 1'b0;
    take = meas_tick && (s.st == cdp_pkg::ST_IDLE);
    nn = 7'h0;
    fld = pwdata[cdp_pkg::F_WIN +: 7];
    v = 16'h0;
    w = 16'h0;
    t = 16'h0;
    sm = 40'h0;
    sqv = 40'h0;
    lt = 7'h0;
    eqv = 7'h0;
    kk = 7'h0;
    asum = 32'h0;
    an = 16'h0;
    nd = cdp_pkg::cdp_dec_e'(pwdata[cdp_pkg::F_DEC +: 3]);
    nx.rec.valid = 1'b0;
    nx.pready = 1'b0;
    nx.pslverr = 1'b0;
    nx.msc = tick ? 32'h0 : s.msc + 32'h1;

    // ------------------------------------------------------------
    // debounce
    // ------------------------------------------------------------
    nx.sy = {s.sy[1:0], pulse_pin};
    if (s.sy[2] == s.sy[1] && s.sy[2] != s.flt) begin
      if (s.filt == 16'h0 || (tick && s.db + 16'h1 >= s.filt)) begin
        nx.flt = s.sy[2];
        nx.db = 16'h0;
      end else if (tick) begin
        nx.db = s.db + 16'h1;
      end
    end else begin
      nx.db = 16'h0;
    end
    p = nx.flt & ~s.flt;

    // ------------------------------------------------------------
    // pulse counters
    // ------------------------------------------------------------
    if ((s.mode == cdp_pkg::M_INTV && take) ||
        (s.mode == cdp_pkg::M_DAY && midnight)) begin
      nx.pcnt = {15'h0, p};
    end else begin
      nx.pcnt = s.pcnt + {15'h0, p};
    end
    if (rec_tick && s.dec == cdp_pkg::D_SUM) begin
      nx.sacc = {15'h0, p};
    end else begin
      nx.sacc = s.sacc + {15'h0, p};
    end

    // ------------------------------------------------------------
    // analogue averaging
    // ------------------------------------------------------------
    asum = s.a_sum + (adc_valid ? {16'h0, adc_data} : 32'h0);
    an = s.a_n + {15'h0, adc_valid};
    nx.a_sum = asum;
    nx.a_n = an;
    if (tick) begin
      if (s.a_ms + 16'h1 >= s.filt) begin
        nx.av_sum = asum;
        nx.av_n = an;
        nx.a_sum = 32'h0;
        nx.a_n = 16'h0;
        nx.a_ms = 16'h0;
      end else begin
        nx.a_ms = s.a_ms + 16'h1;
      end
    end

    // ------------------------------------------------------------
    // decay engine
    // ------------------------------------------------------------
    case (s.st)
      cdp_pkg::ST_IDLE: begin
        if (take && s.mode == cdp_pkg::M_ANA) begin
          if (s.av_n != 16'h0) begin
            nx.rem = 40'h0;
            nx.dvd = {8'h0, s.av_sum};
            nx.dvs = s.av_n;
            nx.bitc = 6'h0;
            nx.st = cdp_pkg::ST_AVG;
          end else begin
            nx.st = cdp_pkg::ST_PUSH;
          end
        end else if (take) begin
          nx.meas = s.pcnt;
          nx.st = cdp_pkg::ST_PUSH;
        end
      end
      cdp_pkg::ST_AVG, cdp_pkg::ST_DIV: begin
        {nx.rem, nx.dvd} = div_step(s.rem, s.dvd, s.dvs);
        nx.bitc = s.bitc + 6'h1;
        if (s.bitc == cdp_pkg::DIV_LAST) begin
          if (s.st == cdp_pkg::ST_AVG) begin
            nx.meas = nx.dvd[15:0];
            nx.st = cdp_pkg::ST_PUSH;
          end else if (s.dec == cdp_pkg::D_RMS) begin
            nx.root = 16'h0;
            nx.bitc = cdp_pkg::SQRT_TOP;
            nx.st = cdp_pkg::ST_SQRT;
          end else begin
            nx.result = nx.dvd[15:0];
            nx.st = cdp_pkg::ST_IDLE;
          end
        end
      end
      cdp_pkg::ST_PUSH: begin
        nx.win[s.wp] = s.meas;
        nx.wp = s.wp + 6'h1;
        if (s.nfill != cdp_pkg::WIN_MAX) begin
          nx.nfill = s.nfill + 7'h1;
        end
        nn = (nx.nfill < s.win_n) ? nx.nfill : s.win_n;
        nx.n = nn;
        nx.i = 7'h0;
        nx.mn = 16'hffff;
        nx.mx = 16'h0;
        nx.sum = 40'h0;
        nx.sq = 40'h0;
        if (s.dec == cdp_pkg::D_OFF) begin
          nx.result = s.meas;
          nx.st = cdp_pkg::ST_IDLE;
        end else if (s.dec == cdp_pkg::D_SUM) begin
          nx.st = cdp_pkg::ST_IDLE;
        end else begin
          nx.st = cdp_pkg::ST_SCAN;
        end
      end
      cdp_pkg::ST_SCAN: begin
        v = s.win[widx(s.wp, s.i)];
        w = (v < s.mn) ? v : s.mn;
        nx.mn = w;
        nx.mx = (v > s.mx) ? v : s.mx;
        sm = s.sum + {24'h0, v};
        sqv = s.sq + {8'h0, 32'(v) * 32'(v)};
        nx.sum = sm;
        nx.sq = sqv;
        nx.i = s.i + 7'h1;
        if (s.i == s.n - 7'h1) begin
          nx.rem = 40'h0;
          nx.dvs = {9'h0, s.n};
          nx.bitc = 6'h0;
          nx.j = 7'h0;
          nx.less = 7'h0;
          nx.eq = 7'h0;
          case (s.dec)
            cdp_pkg::D_MIN: begin
              nx.result = w;
              nx.st = cdp_pkg::ST_IDLE;
            end
            cdp_pkg::D_MAX: begin
              nx.result = nx.mx;
              nx.st = cdp_pkg::ST_IDLE;
            end
            cdp_pkg::D_MED: begin
              nx.i = 7'h0;
              nx.st = cdp_pkg::ST_MED;
            end
            cdp_pkg::D_RMS: begin
              nx.dvd = sqv;
              nx.st = cdp_pkg::ST_DIV;
            end
            default: begin
              nx.dvd = sm;
              nx.st = cdp_pkg::ST_DIV;
            end
          endcase
        end
      end
      cdp_pkg::ST_SQRT: begin
        t = s.root | (16'h1 << s.bitc);
        if (32'(t) * 32'(t) <= s.dvd[31:0]) begin
          nx.root = t;
        end
        nx.bitc = s.bitc - 6'h1;
        if (s.bitc == 6'h0) begin
          nx.result = nx.root;
          nx.st = cdp_pkg::ST_IDLE;
        end
      end
      cdp_pkg::ST_MED: begin
        v = s.win[widx(s.wp, s.i)];
        w = s.win[widx(s.wp, s.j)];
        lt = s.less + {6'h0, w < v};
        eqv = s.eq + {6'h0, w == v};
        kk = (s.n - 7'h1) >> 1;
        if (s.j == s.n - 7'h1) begin
          if (lt <= kk && lt + eqv > kk) begin
            nx.result = v;
            nx.st = cdp_pkg::ST_IDLE;
          end else begin
            nx.i = s.i + 7'h1;
            nx.j = 7'h0;
            nx.less = 7'h0;
            nx.eq = 7'h0;
          end
        end else begin
          nx.j = s.j + 7'h1;
          nx.less = lt;
          nx.eq = eqv;
        end
      end
      default: begin
        nx.st = cdp_pkg::ST_IDLE;
      end
    endcase

    // ------------------------------------------------------------
    // record output
    // ------------------------------------------------------------
    if (rec_tick) begin
      nx.rec.valid = 1'b1;
      if (s.dec == cdp_pkg::D_SUM) begin
        nx.rec.value = s.sacc;
      end else if (s.dec == cdp_pkg::D_OFF) begin
        nx.rec.value = s.meas;
      end else begin
        nx.rec.value = s.result;
      end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    if (psel && penable && !s.pready) begin
      nx.pready = 1'b1;
      nx.pslverr = !reg_hit(paddr);
      case (paddr)
        cdp_pkg::A_CTRL: begin
          nx.prdata = 32'h0;
          nx.prdata[cdp_pkg::F_MODE +: 2] = s.mode;
          nx.prdata[cdp_pkg::F_DEC +: 3] = s.dec;
          if (s.dec != cdp_pkg::D_SUM) begin
            nx.prdata[cdp_pkg::F_WIN +: 7] = s.win_n;
          end
        end
        cdp_pkg::A_FILT: nx.prdata = {16'h0, s.filt};
        cdp_pkg::A_MEAS: nx.prdata = {16'h0, s.meas};
        cdp_pkg::A_REC: nx.prdata = {16'h0, s.result};
        cdp_pkg::A_CNT: nx.prdata = {16'h0, s.pcnt};
        cdp_pkg::A_STAT: begin
          nx.prdata = 32'h0;
          nx.prdata[cdp_pkg::F_BUSY] = (s.st != cdp_pkg::ST_IDLE);
          nx.prdata[cdp_pkg::F_ERR] = s.err;
          nx.prdata[cdp_pkg::F_LVL] = s.flt;
        end
        default: nx.prdata = 32'h0;
      endcase
    end
    if (psel && penable && s.pready && pwrite) begin
      case (paddr)
        cdp_pkg::A_CTRL: begin
          if (pwdata[cdp_pkg::F_MODE +: 2] == 2'h3 ||
              pwdata[cdp_pkg::F_DEC +: 3] == 3'h7 ||
              (nd != cdp_pkg::D_SUM &&
               (fld == 7'h0 || fld > cdp_pkg::WIN_MAX))) begin
            nx.err = 1'b1;
          end else begin
            nx.mode = cdp_pkg::cdp_mode_e'(pwdata[cdp_pkg::F_MODE +: 2]);
            nx.dec = nd;
            if (nd != cdp_pkg::D_SUM) begin
              nx.win_n = fld;
            end
          end
        end
        cdp_pkg::A_FILT: nx.filt = pwdata[15:0];
        cdp_pkg::A_STAT: begin
          if (pwdata[cdp_pkg::F_ERR]) begin
            nx.err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= cdp_pkg::ST_IDLE;
      s.win_n <= cdp_pkg::RST_WIN;
    end else begin
      s <= nx;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rec = s.rec;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_fin;
    s.st != cdp_pkg::ST_IDLE ##1 s.st == cdp_pkg::ST_IDLE;
  endsequence

  AST_DEBOUNCE: assert property (
    s.flt != $past(s.flt) |->
      $past(s.sy[2]) == $past(s.sy[1]) && s.flt == $past(s.sy[2]) &&
      ($past(s.filt) == 16'h0 || $past(s.db) + 16'h1 >= $past(s.filt)))
    else $error("level accepted while input unstable");
  AST_MIN: assert property (
    seq_fin ##0 s.dec == cdp_pkg::D_MIN |-> s.result <= s.meas)
    else $error("min result above newest value");
  AST_MAX: assert property (
    seq_fin ##0 s.dec == cdp_pkg::D_MAX |-> s.result >= s.meas)
    else $error("max result below newest value");
  AST_AVG: assert property (
    seq_fin ##0 s.dec == cdp_pkg::D_AVG |->
      s.result >= s.mn && s.result <= s.mx)
    else $error("mean outside window range");
  AST_MED: assert property (
    seq_fin ##0 s.dec == cdp_pkg::D_MED |->
      s.result >= s.mn && s.result <= s.mx)
    else $error("median outside window range");
  AST_RMS: assert property (
    seq_fin ##0 s.dec == cdp_pkg::D_RMS |->
      s.result >= s.mn && s.result <= s.mx)
    else $error("rms outside window range");
  AST_SUM: assert property (
    rec_tick && s.dec == cdp_pkg::D_SUM |=>
      rec.valid && rec.value == $past(s.sacc) && s.sacc <= 16'h1)
    else $error("sum record or clear wrong");
  AST_WIN: assert property (
    s.win_n != 7'h0 && s.win_n <= cdp_pkg::WIN_MAX)
    else $error("window count out of range");
  AST_INTV: assert property (
    meas_tick && s.st == cdp_pkg::ST_IDLE &&
      s.mode == cdp_pkg::M_INTV |=>
      s.meas == $past(s.pcnt) && s.pcnt <= 16'h1)
    else $error("interval count not taken and cleared");
  AST_DAY: assert property (
    midnight && s.mode == cdp_pkg::M_DAY |=> s.pcnt <= 16'h1)
    else $error("day count not cleared at midnight");
  AST_OFF: assert property (
    seq_fin ##0 s.dec == cdp_pkg::D_OFF |-> s.result == s.meas)
    else $error("decay off altered the value");

endmodule : cdp_top

// *** tb/cdp_sensor_model.sv ***
// sensor side model: pulse meter contact and analogue sampler
// assumes callers enter its tasks right after a rising pclk edge
`timescale 1ns/100ps

module cdp_sensor_model (
  // clock
  input wire logic pclk,
  // pulse meter
  output logic pulse_pin,
  // analogue sampler
  output logic adc_valid,
  output logic [15:0] adc_data
);

  initial begin
    pulse_pin = 1'b0;
    adc_valid = 1'b0;
    adc_data = 16'h5a5a;
  end

  // ----------------------------------------------------------------
  // contact closed for hi cycles, then open as long
  // ----------------------------------------------------------------
  task automatic pulse(input int hi);
    pulse_pin <= 1'b1;
    repeat (hi) @(posedge pclk);
    pulse_pin <= 1'b0;
    repeat (hi) @(posedge pclk);
  endtask : pulse

  // ----------------------------------------------------------------
  // one sample per cycle, alternating a and b
  // ----------------------------------------------------------------
  task automatic stream(input logic [15:0] a, input logic [15:0] b,
                        input int n);
    for (int i = 0; i < n; i++) begin
      adc_valid <= 1'b1;
      adc_data <= i[0] ? b : a;
      @(posedge pclk);
    end
    adc_valid <= 1'b0;
    // data line no longer valid: show a stale inverse
    adc_data <= ~b;
    @(posedge pclk);
  endtask : stream

endmodule : cdp_sensor_model

// *** tb/channel_decay_and_pulse_counter_tb.sv ***
// self-checking bench for the channel decay and pulse counter
// assumes cdp_pkg and cdp_top compiled first; ms cut to 10 cycles
`timescale 1ns/100ps

module channel_decay_and_pulse_counter_tb;

  localparam int MS = 10;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pulse_pin;
  logic adc_valid;
  logic [15:0] adc_data;
  logic [2:0] ticks;
  cdp_pkg::cdp_rec_s rec;
  logic [31:0] rdat;
  logic rerr;
  int err_total;
  int checks;
  int hist[$];

  cdp_top #(
    .MS_CYCLES(MS)
  ) dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pulse_pin(pulse_pin),
    .adc_valid(adc_valid),
    .adc_data(adc_data),
    .meas_tick(ticks[0]),
    .rec_tick(ticks[1]),
    .midnight(ticks[2]),
    .rec(rec)
  );

  cdp_sensor_model sens_u (
    .pclk(pclk),
    .pulse_pin(pulse_pin),
    .adc_valid(adc_valid),
    .adc_data(adc_data)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // apb master and strobes
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask : rd_chk

  task automatic tick(input int i);
    ticks[i] <= 1'b1;
    @(posedge pclk);
    ticks[i] <= 1'b0;
    @(posedge pclk);
  endtask : tick

  task automatic rec_chk(input int exp);
    ticks[1] <= 1'b1;
    @(posedge pclk);
    ticks[1] <= 1'b0;
    @(negedge pclk);
    chk("rec valid", {31'h0, rec.valid}, 32'h1);
    chk("rec value", {16'h0, rec.value}, exp);
    @(posedge pclk);
  endtask : rec_chk

  // n pulses, then one measurement; spacing covers worst compute
  task automatic gen(input int n);
    repeat (n) sens_u.pulse(4);
    tick(0);
    hist.push_back(n);
    repeat (100) @(posedge pclk);
  endtask : gen

  task automatic restart(input logic [31:0] ctrl, input logic [31:0] f);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    hist.delete();
    wr(cdp_pkg::A_FILT, f);
    wr(cdp_pkg::A_CTRL, ctrl);
  endtask : restart

  // ----------------------------------------------------------------
  // reference decay over the newest x values
  // ----------------------------------------------------------------
  function automatic int dec_val(int d, int x);
    int v[$];
    int k;
    int s;
    int q;
    int r;
    k = (x < hist.size()) ? x : hist.size();
    s = 0;
    q = 0;
    r = 0;
    for (int i = 1; i <= k; i++) v.push_back(hist[hist.size() - i]);
    v.sort();
    foreach (v[i]) begin
      s += v[i];
      q += v[i] * v[i];
    end
    while ((r + 1) * (r + 1) <= q / k) r++;
    case (d)
      1: return v[0];
      2: return v[k - 1];
      3: return s / k;
      4: return v[(k - 1) / 2];
      5: return r;
      default: return hist[hist.size() - 1];
    endcase
  endfunction : dec_val

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int x;
    logic [15:0] a;
    logic [15:0] b;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ticks = 3'h0;
    err_total = 0;
    checks = 0;
    void'($urandom(47));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("ctrl", cdp_pkg::A_CTRL, 32'h100);
    rd_chk("filt", cdp_pkg::A_FILT, 32'h0);
    wr(cdp_pkg::A_CTRL, 32'h4104);
    rd_chk("ctrl", cdp_pkg::A_CTRL, 32'h100);
    rd_chk("stat", cdp_pkg::A_STAT, 32'h2);
    wr(cdp_pkg::A_STAT, 32'h2);
    rd_chk("stat", cdp_pkg::A_STAT, 32'h0);
    wr(cdp_pkg::A_CTRL, 32'h0008);
    rd_chk("stat", cdp_pkg::A_STAT, 32'h2);
    wr(cdp_pkg::A_CTRL, 32'h4008);
    rd_chk("ctrl", cdp_pkg::A_CTRL, 32'h4008);
    wr(cdp_pkg::A_CTRL, 32'h4118);
    rd_chk("ctrl", cdp_pkg::A_CTRL, 32'h18);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", {31'h0, rerr}, 32'h1);
    chk("unmapped", rdat, 32'h0);
    // glitch shorter than 3 ms, then a clean pulse
    restart(32'h100, 32'h3);
    sens_u.pulse(5);
    sens_u.pulse(60);
    rd_chk("cnt", cdp_pkg::A_CNT, 32'h1);
    for (int d = 0; d < 6; d++) begin
      x = $urandom_range(1, 8);
      restart(32'(x * 256 + d * 4), 32'h0);
      repeat (6) gen($urandom_range(0, 7));
      rd_chk("meas", cdp_pkg::A_MEAS, hist[hist.size() - 1]);
      rd_chk("cnt", cdp_pkg::A_CNT, 32'h0);
      rd_chk("rec", cdp_pkg::A_REC, dec_val(d, x));
      rec_chk(dec_val(d, x));
    end
    // long record interval: sum keeps every pulse
    restart(32'h0018, 32'h0);
    gen(3);
    gen(2);
    rec_chk(5);
    gen(1);
    rec_chk(1);
    restart(32'h0101, 32'h0);
    gen(2);
    gen(3);
    rd_chk("meas", cdp_pkg::A_MEAS, 32'h5);
    rd_chk("cnt", cdp_pkg::A_CNT, 32'h5);
    tick(2);
    rd_chk("cnt", cdp_pkg::A_CNT, 32'h0);
    // analogue: 1 ms window of alternating samples, same parity
    restart(32'h0102, 32'h1);
    a = 16'($urandom);
    b = a ^ (16'($urandom) & 16'hfffe);
    fork
      sens_u.stream(a, b, 200);
      begin
        repeat (100) @(posedge pclk);
        tick(0);
      end
    join
    repeat (60) @(posedge pclk);
    rd_chk("meas", cdp_pkg::A_MEAS, (32'(a) + 32'(b)) / 2);
    stop_test();
  end

endmodule : channel_decay_and_pulse_counter_tb
